// ---- shared/ppc_pkg.sv ----
// Purpose: Shared constants and types for the indirect pin configuration block
// Assumes: 32-bit AXI4-Lite, register index times four gives the byte address
// Notes: Port width is eight pins
package ppc_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] PPC_P0_IDX = 8'h9E;
    localparam logic [7:0] PPC_P1_IDX = 8'h9F;
    localparam int PPC_AW = 12;
    localparam logic [11:0] PPC_P0_ADDR = {2'h0, PPC_P0_IDX, 2'h0};
    localparam logic [11:0] PPC_P1_ADDR = {2'h0, PPC_P1_IDX, 2'h0};
    localparam logic [7:0] PPC_CFG_RST = 8'h00;
    localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PPC_RESP_DECERR = 2'h3;

    // --------------------------------------------------------------
    // Field layout of port_pin_config
    // --------------------------------------------------------------
    localparam int PPC_MODE_HI = 7;
    localparam int PPC_MODE_LO = 5;
    localparam int PPC_IN_HI = 6;
    localparam int PPC_DIR_BIT = 4;
    localparam int PPC_FLAG_BIT = 3;
    localparam int PPC_PIN_HI = 2;
    localparam int PPC_PIN_LO = 0;

    // --------------------------------------------------------------
    // Mode encodings
    // --------------------------------------------------------------
    localparam logic [2:0] PPC_OUT_NORMAL = 3'h0;
    localparam logic [2:0] PPC_OUT_HIGH = 3'h3;
    localparam logic [1:0] PPC_IN_NOPULL = 2'h0;
    localparam logic [1:0] PPC_IN_PULLDN = 2'h1;
    localparam logic [1:0] PPC_IN_PULLUP = 2'h2;
    localparam logic [1:0] PPC_IN_OFF = 2'h3;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic {PPC_WR_COLLECT, PPC_WR_RESP} ppc_wr_e;

    typedef struct packed {
        logic [7:0][2:0] out_mode;
        logic [7:0][1:0] in_mode;
        logic [2:0] sel_pin;
        logic sel_dir;
    } ppc_port_s;

    typedef struct packed {
        logic [7:0] high_drive;
        logic [7:0] in_buf_en;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } ppc_pins_s;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } ppc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ppc_axi_rsp_s;

    // Word match ignoring the byte offset
    function automatic logic ppc_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
        ppc_hit = (addr[11:2] == reg_addr[11:2]);
    endfunction

    // Pad driver controls from stored modes
    function automatic ppc_pins_s ppc_decode(input ppc_port_s cfg);
        ppc_pins_s p;
        p = '0;
        for (int i = 0; i < 8; i++)
        begin
            p.high_drive[i] = (cfg.out_mode[i] == PPC_OUT_HIGH);
            p.in_buf_en[i] = (cfg.in_mode[i] != PPC_IN_OFF);
            p.pull_up[i] = (cfg.in_mode[i] == PPC_IN_PULLUP);
            p.pull_down[i] = (cfg.in_mode[i] == PPC_IN_PULLDN);
        end
        ppc_decode = p;
    endfunction
endpackage

// ---- hw/ppc_port_cfg.sv ----
// Purpose: Mode storage and indirect access for one eight-pin port
// Assumes: wr_en is a one-cycle strobe from the bus slave
// Notes: rd_data is combinational from stored state
`timescale 1ns/1ps
module ppc_port_cfg
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // Stored configuration
    output ppc_pkg::ppc_port_s cfg
);
    ppc_pkg::ppc_port_s st_d;
    ppc_pkg::ppc_port_s st_q;
    logic [2:0] pin;
    logic [2:0] mode;
    logic dir;
    logic flag;

    assign pin = wr_data[ppc_pkg::PPC_PIN_HI:ppc_pkg::PPC_PIN_LO];
    assign mode = wr_data[ppc_pkg::PPC_MODE_HI:ppc_pkg::PPC_MODE_LO];
    assign dir = wr_data[ppc_pkg::PPC_DIR_BIT];
    assign flag = wr_data[ppc_pkg::PPC_FLAG_BIT];
    assign cfg = st_q;

    always_comb
    begin
        st_d = st_q;
        if (wr_en)
        begin
            if (flag)
            begin
                st_d.sel_pin = pin;
                st_d.sel_dir = dir;
            end
            else if (dir)
            begin
                st_d.in_mode[pin] = mode[1:0];
            end
            // illegal drive code dropped, pin keeps its mode
            else if (mode == ppc_pkg::PPC_OUT_NORMAL || mode == ppc_pkg::PPC_OUT_HIGH)
            begin
                st_d.out_mode[pin] = mode;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    always_comb
    begin
        rd_data = ppc_pkg::PPC_CFG_RST;
        if (st_q.sel_dir)
            rd_data[ppc_pkg::PPC_IN_HI:ppc_pkg::PPC_MODE_LO] = st_q.in_mode[st_q.sel_pin];
        else
            rd_data[ppc_pkg::PPC_MODE_HI:ppc_pkg::PPC_MODE_LO] = st_q.out_mode[st_q.sel_pin];
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence s_addr_write;
        wr_en && flag;
    endsequence

    sequence s_in_write;
        wr_en && !flag && dir;
    endsequence

    sequence s_out_write;
        wr_en && !flag && !dir;
    endsequence

    property p_sel_store;
        @(posedge clk) disable iff (rst)
        s_addr_write |=> st_q.sel_pin == $past(pin) && st_q.sel_dir == $past(dir);
    endproperty
    a_sel_store: assert property (p_sel_store) else $error("selection not stored");

    property p_addr_no_cfg;
        @(posedge clk) disable iff (rst)
        s_addr_write |=> $stable(st_q.out_mode) && $stable(st_q.in_mode);
    endproperty
    a_addr_no_cfg: assert property (p_addr_no_cfg) else $error("address write changed modes");

    property p_in_update;
        @(posedge clk) disable iff (rst)
        s_in_write |=> st_q.in_mode[$past(pin)] == $past(mode[1:0]) && $stable(st_q.sel_pin);
    endproperty
    a_in_update: assert property (p_in_update) else $error("input mode not written");

    property p_in_keeps_out;
        @(posedge clk) disable iff (rst)
        s_in_write |=> $stable(st_q.out_mode);
    endproperty
    a_in_keeps_out: assert property (p_in_keeps_out) else $error("input write touched output");

    property p_out_keeps_in;
        @(posedge clk) disable iff (rst)
        s_out_write |=> $stable(st_q.in_mode);
    endproperty
    a_out_keeps_in: assert property (p_out_keeps_in) else $error("output write touched input");

    property p_out_legal;
        @(posedge clk) disable iff (rst)
        s_out_write ##0 (mode == ppc_pkg::PPC_OUT_HIGH) |=> st_q.out_mode[$past(pin)] == ppc_pkg::PPC_OUT_HIGH;
    endproperty
    a_out_legal: assert property (p_out_legal) else $error("high drive not written");

    property p_out_illegal;
        @(posedge clk) disable iff (rst)
        s_out_write ##0 (mode != ppc_pkg::PPC_OUT_NORMAL && mode != ppc_pkg::PPC_OUT_HIGH)
            |=> $stable(st_q.out_mode);
    endproperty
    a_out_illegal: assert property (p_out_illegal) else $error("illegal drive code stored");

    property p_reset_clear;
        @(posedge clk) rst |=> st_q == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");
endmodule

// ---- hw/ppc_top.sv ----
// Purpose: AXI4-Lite slave for the two indirect pin configuration registers
// Assumes: Single clock, synchronous active-high reset
// Notes: Only byte lane 0 carries register data; upper bits read zero
`timescale 1ns/1ps
// Summary of operation
// - Input mode 00 buffer on, 01 pull-down, 10 pull-up, 11 buffer off.
// - Output mode 000 normal drive, 011 high drive; other codes illegal.
// - Direction bit 0 targets output configuration, 1 targets input configuration.
// - Address-flag write stores pin address and direction for later reads.
// - Address-flag write ignores mode field; no pin configuration changes.
// - Flag clear write replaces addressed pin's input mode, or its output mode when the code is legal.
// - Read returns the selected pin's stored mode, output mode in bits 7:5, input mode in bits 6:5.
// - Each port keeps separate input and output modes for all eight pins.
// - Pin address value selects the pin of the same number.
module ppc_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire ppc_pkg::ppc_axi_req_s s_axi_req,
    output ppc_pkg::ppc_axi_rsp_s s_axi_rsp,
    // Pad controls
    output ppc_pkg::ppc_pins_s port0_pins,
    output ppc_pkg::ppc_pins_s port1_pins
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        ppc_pkg::ppc_wr_e wr_st;
        logic aw_got;
        logic [11:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ppc_bus_s;

    ppc_bus_s st_d;
    ppc_bus_s st_q;
    ppc_pkg::ppc_port_s cfg0;
    ppc_pkg::ppc_port_s cfg1;
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic awready;
    logic wready;
    logic arready;
    logic wr_fire;
    logic wr_p0;
    logic wr_p1;
    logic wr_mapped;
    logic rd_p0;
    logic rd_p1;

    // --------------------------------------------------------------
    // Write path
    // --------------------------------------------------------------
    assign awready = (st_q.wr_st == ppc_pkg::PPC_WR_COLLECT) && !st_q.aw_got;
    assign wready = (st_q.wr_st == ppc_pkg::PPC_WR_COLLECT) && !st_q.w_got;
    assign wr_fire = (st_q.wr_st == ppc_pkg::PPC_WR_COLLECT) && st_q.aw_got && st_q.w_got;
    assign wr_mapped = ppc_pkg::ppc_hit(st_q.awaddr, ppc_pkg::PPC_P0_ADDR)
                       || ppc_pkg::ppc_hit(st_q.awaddr, ppc_pkg::PPC_P1_ADDR);
    // Lane 0 cleared means no register byte written
    assign wr_p0 = wr_fire && st_q.wlane0 && ppc_pkg::ppc_hit(st_q.awaddr, ppc_pkg::PPC_P0_ADDR);
    assign wr_p1 = wr_fire && st_q.wlane0 && ppc_pkg::ppc_hit(st_q.awaddr, ppc_pkg::PPC_P1_ADDR);

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------
    assign arready = !st_q.rvalid;
    assign rd_p0 = ppc_pkg::ppc_hit(s_axi_req.araddr, ppc_pkg::PPC_P0_ADDR);
    assign rd_p1 = ppc_pkg::ppc_hit(s_axi_req.araddr, ppc_pkg::PPC_P1_ADDR);

    always_comb
    begin
        st_d = st_q;
        if (s_axi_req.awvalid && awready)
        begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_req.awaddr;
        end
        if (s_axi_req.wvalid && wready)
        begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_req.wdata[7:0];
            st_d.wlane0 = s_axi_req.wstrb[0];
        end
        case (st_q.wr_st)
            ppc_pkg::PPC_WR_COLLECT:
            begin
                if (wr_fire)
                begin
                    st_d.wr_st = ppc_pkg::PPC_WR_RESP;
                    st_d.aw_got = 1'b0;
                    st_d.w_got = 1'b0;
                    st_d.bvalid = 1'b1;
                    st_d.bresp = wr_mapped ? ppc_pkg::PPC_RESP_OKAY : ppc_pkg::PPC_RESP_DECERR;
                end
            end
            ppc_pkg::PPC_WR_RESP:
            begin
                if (s_axi_req.bready)
                begin
                    st_d.wr_st = ppc_pkg::PPC_WR_COLLECT;
                    st_d.bvalid = 1'b0;
                end
            end
            default:
            begin
                st_d.wr_st = ppc_pkg::PPC_WR_COLLECT;
            end
        endcase
        if (st_q.rvalid && s_axi_req.rready)
        begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_req.arvalid && arready)
        begin
            st_d.rvalid = 1'b1;
            st_d.rdata = '0;
            st_d.rresp = ppc_pkg::PPC_RESP_OKAY;
            if (rd_p0)
                st_d.rdata[7:0] = rd0;
            else if (rd_p1)
                st_d.rdata[7:0] = rd1;
            else
                st_d.rresp = ppc_pkg::PPC_RESP_DECERR;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign s_axi_rsp.awready = awready;
    assign s_axi_rsp.wready = wready;
    assign s_axi_rsp.bvalid = st_q.bvalid;
    assign s_axi_rsp.bresp = st_q.bresp;
    assign s_axi_rsp.arready = arready;
    assign s_axi_rsp.rvalid = st_q.rvalid;
    assign s_axi_rsp.rdata = st_q.rdata;
    assign s_axi_rsp.rresp = st_q.rresp;

    // --------------------------------------------------------------
    // Port storage
    // --------------------------------------------------------------
    // one storage block per port
    ppc_port_cfg u_port0
    (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_p0),
        .wr_data(st_q.wdata),
        .rd_data(rd0),
        .cfg(cfg0)
    );

    ppc_port_cfg u_port1
    (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_p1),
        .wr_data(st_q.wdata),
        .rd_data(rd1),
        .cfg(cfg1)
    );

    assign port0_pins = ppc_pkg::ppc_decode(cfg0);
    assign port1_pins = ppc_pkg::ppc_decode(cfg1);

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence s_pin5_high_write;
        wr_p1 && !st_q.wdata[ppc_pkg::PPC_FLAG_BIT] && !st_q.wdata[ppc_pkg::PPC_DIR_BIT]
            && st_q.wdata[ppc_pkg::PPC_PIN_HI:ppc_pkg::PPC_PIN_LO] == 3'h5
            && st_q.wdata[ppc_pkg::PPC_MODE_HI:ppc_pkg::PPC_MODE_LO] == ppc_pkg::PPC_OUT_HIGH;
    endsequence

    property p_pin_select;
        @(posedge clk) disable iff (rst)
        s_pin5_high_write |=> port1_pins.high_drive[5] && $stable(port1_pins.high_drive[4]);
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("pin 5 not set to high drive");

    property p_pullup_decode;
        @(posedge clk) disable iff (rst)
        cfg0.in_mode[5] == ppc_pkg::PPC_IN_PULLUP
            |-> port0_pins.pull_up[5] && !port0_pins.pull_down[5] && port0_pins.in_buf_en[5];
    endproperty
    a_pullup_decode: assert property (p_pullup_decode) else $error("pull-up decode wrong");

    property p_off_decode;
        @(posedge clk) disable iff (rst)
        cfg1.in_mode[3] == ppc_pkg::PPC_IN_OFF |-> !port1_pins.in_buf_en[3] && !port1_pins.pull_up[3];
    endproperty
    a_off_decode: assert property (p_off_decode) else $error("buffer-off decode wrong");

    property p_read_return;
        @(posedge clk) disable iff (rst)
        s_axi_req.arvalid && arready && rd_p0
            |=> st_q.rvalid && st_q.rdata == {24'h0, $past(rd0)} && st_q.rresp == ppc_pkg::PPC_RESP_OKAY;
    endproperty
    a_read_return: assert property (p_read_return) else $error("read data not selected mode");

    property p_write_resp;
        @(posedge clk) disable iff (rst)
        (wr_p0 || wr_p1) |=> st_q.bvalid && st_q.bresp == ppc_pkg::PPC_RESP_OKAY;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write not answered next cycle");
endmodule

// ---- tb/ppc_tb.sv ----
// Purpose: Self-checking bench for the indirect pin configuration block
// Assumes: AXI4-Lite master in this bench, one write or read at a time
// Notes: Bus handshakes are judged at the falling edge, released after the rising one
`timescale 1ns/1ps

`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("FAIL t=%0t got %0h expected %0h", $time, (got), (exp)); \
        end \
    end

module testbench;
    logic clk;
    logic rst;
    ppc_pkg::ppc_axi_req_s req;
    ppc_pkg::ppc_axi_rsp_s rsp;
    ppc_pkg::ppc_pins_s pins0;
    ppc_pkg::ppc_pins_s pins1;
    int bad_count;
    int samples_checked;
    localparam logic [11:0] A0 = ppc_pkg::PPC_P0_ADDR;
    localparam logic [11:0] A1 = ppc_pkg::PPC_P1_ADDR;

    ppc_top uut
    (
        .clk(clk),
        .rst(rst),
        .s_axi_req(req),
        .s_axi_rsp(rsp),
        .port0_pins(pins0),
        .port1_pins(pins1)
    );

    initial
    begin
        clk = 1'b0;
    end
    always #2.5 clk = ~clk;

    // ----------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic give_up();
        bad_count++;
        $display("FAIL t=%0t bus handshake timed out", $time);
        summarize();
    endtask

    // ----------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------
    // Falling-edge sampling sees exactly what the next rising edge will take
    task automatic bus_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        int n;
        logic aw_ok;
        logic w_ok;
        logic b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        resp = 2'h0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= s;
        req.bready <= 1'b1;
        for (n = 0; n < 40 && !b_ok; n++)
        begin
            @(negedge clk);
            aw_ok = aw_ok | (req.awvalid & (rsp.awready === 1'b1));
            w_ok = w_ok | (req.wvalid & (rsp.wready === 1'b1));
            b_ok = (rsp.bvalid === 1'b1);
            if (b_ok)
                resp = rsp.bresp;
            @(posedge clk);
            if (aw_ok)
                req.awvalid <= 1'b0;
            if (w_ok)
                req.wvalid <= 1'b0;
            if (b_ok)
                req.bready <= 1'b0;
        end
        if (!b_ok)
            give_up();
        @(posedge clk);
    endtask

    task automatic bus_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ar_ok;
        logic r_ok;
        ar_ok = 1'b0;
        r_ok = 1'b0;
        d = 32'h00000000;
        resp = 2'h0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (n = 0; n < 40 && !r_ok; n++)
        begin
            @(negedge clk);
            ar_ok = ar_ok | (req.arvalid & (rsp.arready === 1'b1));
            r_ok = (rsp.rvalid === 1'b1);
            if (r_ok)
            begin
                d = rsp.rdata;
                resp = rsp.rresp;
            end
            @(posedge clk);
            if (ar_ok)
                req.arvalid <= 1'b0;
            if (r_ok)
                req.rready <= 1'b0;
        end
        if (!r_ok)
            give_up();
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] resp;
        bus_write(a, d, 4'hF, resp);
        `CHK(resp, ppc_pkg::PPC_RESP_OKAY)
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] resp;
        bus_read(a, d, resp);
        `CHK(resp, ppc_pkg::PPC_RESP_OKAY)
        `CHK(d, {24'h000000, exp})
    endtask

    // Flag write carries a high-drive mode that must not land anywhere
    task automatic sel(input logic [11:0] a, input logic dir, input logic [2:0] pin);
        wr(a, {ppc_pkg::PPC_OUT_HIGH, dir, 1'b1, pin});
    endtask

    task automatic pins_chk(input logic port, input ppc_pkg::ppc_pins_s exp);
        @(negedge clk);
        `CHK(port ? pins1 : pins0, exp)
        @(posedge clk);
    endtask

    function automatic ppc_pkg::ppc_pins_s mk(input logic [7:0] hd, input logic [7:0] ib,
                                               input logic [7:0] pu, input logic [7:0] pd);
        mk = {hd, ib, pu, pd};
    endfunction

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        pins_chk(1'b0, mk(8'h00, 8'hFF, 8'h00, 8'h00));
        pins_chk(1'b1, mk(8'h00, 8'hFF, 8'h00, 8'h00));
        rd_chk(A0, 8'h00);
        rd_chk(A1, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_input();
        for (int m = 0; m < 4; m++)
        begin
            wr(A0, {1'b0, m[1:0], 1'b1, 1'b0, 3'h5});
            pins_chk(1'b0, mk(8'h00, (m == 3) ? 8'hDF : 8'hFF, (m == 2) ? 8'h20 : 8'h00,
                (m == 1) ? 8'h20 : 8'h00));
            sel(A0, 1'b1, 3'h5);
            rd_chk(A0, {1'b0, m[1:0], 5'h00});
        end
        $display("input mode test done");
    endtask

    task automatic t_flag();
        sel(A0, 1'b0, 3'h2);
        pins_chk(1'b0, mk(8'h00, 8'hDF, 8'h00, 8'h00));
        rd_chk(A0, 8'h00);
        sel(A0, 1'b1, 3'h5);
        rd_chk(A0, 8'h60);
        sel(A0, 1'b1, 3'h4);
        rd_chk(A0, 8'h00);
        $display("address flag test done");
    endtask

    task automatic t_output();
        wr(A1, {ppc_pkg::PPC_OUT_HIGH, 1'b0, 1'b0, 3'h7});
        pins_chk(1'b1, mk(8'h80, 8'hFF, 8'h00, 8'h00));
        sel(A1, 1'b0, 3'h7);
        rd_chk(A1, 8'h60);
        // Illegal output code is dropped, stored mode stays
        wr(A1, {3'h5, 1'b0, 1'b0, 3'h7});
        pins_chk(1'b1, mk(8'h80, 8'hFF, 8'h00, 8'h00));
        rd_chk(A1, 8'h60);
        wr(A1, {ppc_pkg::PPC_OUT_NORMAL, 1'b0, 1'b0, 3'h7});
        pins_chk(1'b1, mk(8'h00, 8'hFF, 8'h00, 8'h00));
        rd_chk(A1, 8'h00);
        pins_chk(1'b0, mk(8'h00, 8'hDF, 8'h00, 8'h00));
        wr(A1, {ppc_pkg::PPC_OUT_HIGH, 1'b0, 1'b0, 3'h5});
        pins_chk(1'b1, mk(8'h20, 8'hFF, 8'h00, 8'h00));
        sel(A1, 1'b0, 3'h5);
        rd_chk(A1, 8'h60);
        $display("output mode test done");
    endtask

    task automatic t_separate();
        for (int i = 0; i < 8; i++)
        begin
            wr(A1, {(i % 2 == 0) ? 3'h3 : 3'h0, 1'b0, 1'b0, i[2:0]});
            wr(A1, {1'b0, i[1:0], 1'b1, 1'b0, i[2:0]});
        end
        pins_chk(1'b1, mk(8'h55, 8'h77, 8'h44, 8'h22));
        pins_chk(1'b0, mk(8'h00, 8'hDF, 8'h00, 8'h00));
        for (int i = 0; i < 8; i++)
        begin
            sel(A1, 1'b0, i[2:0]);
            rd_chk(A1, {(i % 2 == 0) ? 3'h3 : 3'h0, 5'h00});
            sel(A1, 1'b1, i[2:0]);
            rd_chk(A1, {1'b0, i[1:0], 5'h00});
        end
        $display("per-pin storage test done");
    endtask

    task automatic t_unmapped();
        logic [1:0] resp;
        logic [31:0] d;
        bus_write(12'h100, {ppc_pkg::PPC_OUT_HIGH, 1'b0, 1'b0, 3'h0}, 4'hF, resp);
        `CHK(resp, ppc_pkg::PPC_RESP_DECERR)
        // Lane 0 off: nothing stored
        bus_write(A0, {ppc_pkg::PPC_OUT_HIGH, 1'b0, 1'b0, 3'h0}, 4'h0, resp);
        `CHK(resp, ppc_pkg::PPC_RESP_OKAY)
        pins_chk(1'b0, mk(8'h00, 8'hDF, 8'h00, 8'h00));
        pins_chk(1'b1, mk(8'h55, 8'h77, 8'h44, 8'h22));
        bus_read(12'h100, d, resp);
        `CHK(resp, ppc_pkg::PPC_RESP_DECERR)
        `CHK(d, 32'h00000000)
        $display("unmapped access test done");
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        bad_count = 0;
        samples_checked = 0;
        rst = 1'b1;
        req = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_input();
        t_flag();
        t_output();
        t_separate();
        t_unmapped();
        summarize();
    end
endmodule
